// ===== rtl/bcsc_ctrl.sv
// Configuration, enable sequencing, sync pin and telemetry control of the step-down converter.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "bcsc_defines.svh"
module bcsc_ctrl
	import bcsc_pkg::*;
#(
	parameter int          LOCK_WINDOW_CYC = `BCSC_LOCK_WINDOW_US * `BCSC_CLK_MHZ,
	parameter int          SW_HALF_CYC     = 8,
	parameter int          AVG_SHIFT       = 3,
	parameter logic [11:0] TRACK_MIN       = 12'h010
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ctrl_pin,
	input  wire logic        sync_in,
	output logic             sync_out,
	output logic             sync_oe,
	input  wire logic [11:0] vout_strap_resistor,
	input  wire logic [11:0] comp_strap_resistor,
	input  wire logic [11:0] tracking_input,
	input  wire logic [11:0] vout_sense_in,
	input  wire logic [11:0] iout_sample,
	input  wire logic [9:0]  temp_raw,
	input  wire logic        nvm_valid_in,
	input  wire logic [143:0] nvm_image_in,
	input  wire logic [7:0]  nvm_space_in,
	output logic             nvm_wr,
	output logic [143:0]     nvm_image_out,
	output logic [11:0]      vout_target,
	output logic             driver_en,
	output logic             power_good_out,
	output logic             sync_locked,
	output logic             oc_trip
);

	localparam int NCFG = `BCSC_NCFG;
	localparam int LW   = $clog2(LOCK_WINDOW_CYC + 1);
	localparam int SWW  = $clog2(SW_HALF_CYC + 1);
	localparam int ACW  = `BCSC_VOLT_W + AVG_SHIFT;

	logic [15:0]    cfg_r [NCFG];
	logic [NCFG-1:0] dirty_r;
	logic           init_r;
	logic [11:0]    strap_code_r;
	logic [11:0]    comp_code_r;
	logic [7:0]     nvm_left_r;
	logic           store_fail_r;
	logic           aw_held_r;
	logic           w_held_r;
	logic [7:0]     aw_addr_r;
	logic [31:0]    w_data_r;
	logic [3:0]     w_strb_r;
	logic           wr_go;
	logic [1:0]     wr_resp;
	logic [31:0]    rd_data;
	logic [1:0]     rd_resp;
	logic [3:0]     wr_idx;
	logic           cfg_wr;
	logic           cmd_wr;
	bcsc_state_type state_r;
	logic [15:0]    dly_cnt_r;
	logic [15:0]    step_cnt_r;
	logic [11:0]    ramp_r;
	logic [11:0]    prebias_r;
	logic [11:0]    lvl;
	logic [11:0]    out_lvl;
	logic [11:0]    vout_eff;
	logic [11:0]    floor_lvl;
	logic [15:0]    step_rate;
	logic           tick;
	logic           en_now;
	logic           track_en;
	logic           track_ok;
	logic           ctrl_s;
	logic           sync_s;
	logic           sync_d_r;
	logic [LW-1:0]  lock_cnt_r;
	logic [SWW-1:0] sw_cnt_r;
	logic           sw_phase_r;
	logic [ACW-1:0] acc_r;
	logic           warn_r;
	logic [9:0]     temp_r;
	bcsc_sync_type  sync_mode;

	// Byte-lane merge of a 16-bit configuration word.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
	                                        input logic [3:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Factory value of each configuration word.
	function automatic logic [15:0] cfg_default(input int idx);
		unique case (idx)
			0:       cfg_default = `BCSC_DEF_CTRL;
			1:       cfg_default = `BCSC_DEF_VOUT;
			2:       cfg_default = `BCSC_DEF_VOFF;
			3, 4:    cfg_default = `BCSC_DEF_DLY;
			5, 6:    cfg_default = `BCSC_DEF_RAMP;
			7:       cfg_default = `BCSC_DEF_OC_LIM;
			default: cfg_default = `BCSC_DEF_WARN_LIM;
		endcase
	endfunction

	// Storage cost of a commit is the number of parameters that changed.
	function automatic logic [7:0] popcount(input logic [NCFG-1:0] v);
		popcount = 8'h00;
		for (int i = 0; i < NCFG; i++) begin
			popcount = popcount + {7'h00, v[i]};
		end
	endfunction

	bcsc_pin_sync u_ctrl_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_in    (ctrl_pin),
		.level_out (ctrl_s)
	);

	bcsc_pin_sync u_clk_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_in    (sync_in),
		.level_out (sync_s)
	);

	// Decoded configuration fields.
	assign track_en  = cfg_r[`BCSC_IDX_CTRL][`BCSC_CTRL_TRACK_EN];
	assign sync_mode = bcsc_sync_type'(cfg_r[`BCSC_IDX_CTRL][`BCSC_CTRL_SYNC_HI:`BCSC_CTRL_SYNC_LO]);
	assign vout_eff  = cfg_r[`BCSC_IDX_CTRL][`BCSC_CTRL_STRAP_DIS] ?
	                   cfg_r[`BCSC_IDX_VOUT][11:0] : strap_code_r;
	assign floor_lvl = track_en ? 12'h000 : cfg_r[`BCSC_IDX_VOFF][11:0];
	assign track_ok  = tracking_input > TRACK_MIN;

	// Enable source selection; the unused code disables the output.
	always_comb begin
		unique case (bcsc_src_type'(cfg_r[`BCSC_IDX_CTRL][`BCSC_CTRL_SRC_HI:`BCSC_CTRL_SRC_LO]))
			BCSC_SRC_BUS:  en_now = cfg_r[`BCSC_IDX_CTRL][`BCSC_CTRL_OPON];
			BCSC_SRC_PIN:  en_now = ctrl_s;
			BCSC_SRC_BOTH: en_now = cfg_r[`BCSC_IDX_CTRL][`BCSC_CTRL_OPON] & ctrl_s;
			default:       en_now = 1'b0;
		endcase
	end

	// Write handshakes; address and data are taken independently and written together.
	assign wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_idx  = aw_addr_r[5:2];
	assign cfg_wr  = wr_go && aw_addr_r <= `BCSC_OFF_CFG_LAST && aw_addr_r[1:0] == 2'h0 && !init_r
	                 && !(wr_idx == `BCSC_IDX_VOUT && !cfg_r[`BCSC_IDX_CTRL][`BCSC_CTRL_STRAP_DIS]);
	assign cmd_wr  = wr_go && aw_addr_r == `BCSC_OFF_CMD && !init_r;
	// A nominal voltage write while the strap is in force is refused with an error.
	assign wr_resp = (cfg_wr || cmd_wr) ? `BCSC_RESP_OKAY : `BCSC_RESP_SLVERR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r     <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr_r     <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r     <= 1'b1;
			s_axi_awready <= 1'b0;
			aw_addr_r     <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r     <= 1'b0;
			s_axi_awready <= 1'b1;
		end else begin
			s_axi_awready <= ~aw_held_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r     <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data_r     <= 32'h00000000;
			w_strb_r     <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r     <= 1'b1;
			s_axi_wready <= 1'b0;
			w_data_r     <= s_axi_wdata;
			w_strb_r     <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r     <= 1'b0;
			s_axi_wready <= 1'b1;
		end else begin
			s_axi_wready <= ~w_held_r;
		end
	end

	// Write response follows the register update in the same edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `BCSC_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_resp;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux; unmapped offsets and the write-only command word answer with an error.
	always_comb begin
		rd_data = 32'h00000000;
		rd_resp = `BCSC_RESP_OKAY;
		if (s_axi_araddr <= `BCSC_OFF_CFG_LAST && s_axi_araddr[1:0] == 2'h0) begin
			rd_data = {16'h0000, cfg_r[s_axi_araddr[5:2]]};
		end else begin
			unique case (s_axi_araddr)
				`BCSC_OFF_STATUS:   rd_data = {23'h000000, store_fail_r, warn_r, oc_trip,
				                               sync_locked, driver_en, power_good_out, state_r};
				`BCSC_OFF_TARGET:   rd_data = {20'h00000, vout_target};
				`BCSC_OFF_IOUT:     rd_data = {20'h00000, acc_r[ACW-1:AVG_SHIFT]};
				`BCSC_OFF_TEMP:     rd_data = {{22{temp_r[9]}}, temp_r};
				`BCSC_OFF_NVM_LEFT: rd_data = {24'h000000, nvm_left_r};
				`BCSC_OFF_STRAP:    rd_data = {4'h0, comp_code_r, 4'h0, strap_code_r};
				default:            rd_resp = `BCSC_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `BCSC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= rd_resp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= ~s_axi_rvalid;
		end
	end

	// Working configuration: reset clears it, the first edge after release loads the stored
	// image or the factory values, later bus writes change only this volatile copy.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_r       <= 1'b1;
			dirty_r      <= '0;
			strap_code_r <= 12'h000;
			comp_code_r  <= 12'h000;
			for (int i = 0; i < NCFG; i++) begin
				cfg_r[i] <= 16'h0000;
			end
		end else if (init_r) begin
			init_r       <= 1'b0;
			strap_code_r <= vout_strap_resistor;
			comp_code_r  <= comp_strap_resistor;
			for (int i = 0; i < NCFG; i++) begin
				cfg_r[i] <= nvm_valid_in ? nvm_image_in[i*16 +: 16] : cfg_default(i);
			end
		end else begin
			// A write in the same edge as a commit keeps its parameter marked as changed.
			if (cmd_wr && nvm_wr_ok()) begin
				dirty_r <= '0;
			end
			if (cfg_wr) begin
				cfg_r[wr_idx]   <= merge16(cfg_r[wr_idx], w_data_r, w_strb_r);
				dirty_r[wr_idx] <= 1'b1;
			end
		end
	end

	// A commit is taken when a store command arrives and the changed set fits the space left.
	function automatic logic nvm_wr_ok();
		nvm_wr_ok = (w_data_r[`BCSC_CMD_STORE_ALL] | w_data_r[`BCSC_CMD_STORE_CODE])
		            && popcount(dirty_r) <= nvm_left_r;
	endfunction

	// Commit to the stored image and account for the space it consumes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nvm_wr        <= 1'b0;
			nvm_image_out <= '0;
			nvm_left_r    <= 8'h00;
			store_fail_r  <= 1'b0;
		end else begin
			nvm_wr <= 1'b0;
			if (init_r) begin
				nvm_left_r <= nvm_space_in;
			end else if (cmd_wr && nvm_wr_ok()) begin
				nvm_wr       <= 1'b1;
				nvm_left_r   <= nvm_left_r - popcount(dirty_r);
				store_fail_r <= 1'b0;
				for (int i = 0; i < NCFG; i++) begin
					nvm_image_out[i*16 +: 16] <= cfg_r[i];
				end
			end else if (cmd_wr && (w_data_r[`BCSC_CMD_STORE_ALL] | w_data_r[`BCSC_CMD_STORE_CODE])) begin
				store_fail_r <= 1'b1;
			end
		end
	end

	// Ramp step pacing: rise rate while rising or slewing, fall rate while falling.
	assign step_rate = (state_r == BCSC_ST_FALL) ? cfg_r[`BCSC_IDX_TOFF_FALL] :
	                   cfg_r[`BCSC_IDX_TON_RISE];
	assign tick      = step_cnt_r >= step_rate;

	// The virtual ramp starts from zero so a pre-charged output still meets the rise time.
	always_comb begin
		lvl = ramp_r;
		if (state_r == BCSC_ST_RISE && prebias_r > ramp_r) begin
			lvl = prebias_r;
		end
		out_lvl = (track_en && tracking_input < lvl) ? tracking_input : lvl;
	end

	// Power sequencer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= BCSC_ST_OFF;
			dly_cnt_r  <= 16'h0000;
			step_cnt_r <= 16'h0000;
			ramp_r     <= 12'h000;
			prebias_r  <= 12'h000;
		end else begin
			step_cnt_r <= tick ? 16'h0000 : step_cnt_r + 16'h0001;
			unique case (state_r)
				BCSC_ST_OFF: begin
					dly_cnt_r <= 16'h0000;
					if (en_now) begin
						state_r <= BCSC_ST_ON_DLY;
					end
				end
				BCSC_ST_ON_DLY: begin
					if (!en_now) begin
						state_r <= BCSC_ST_OFF;
					end else if (dly_cnt_r >= cfg_r[`BCSC_IDX_TON_DLY]) begin
						// A held-low tracking input keeps the output parked here.
						if (!track_en || track_ok) begin
							prebias_r  <= vout_sense_in;
							ramp_r     <= 12'h000;
							step_cnt_r <= 16'h0000;
							state_r    <= BCSC_ST_RISE;
						end
					end else begin
						dly_cnt_r <= dly_cnt_r + 16'h0001;
					end
				end
				BCSC_ST_RISE: begin
					if (!en_now) begin
						dly_cnt_r <= 16'h0000;
						state_r   <= BCSC_ST_OFF_DLY;
					end else if (ramp_r >= vout_eff) begin
						state_r <= BCSC_ST_ON;
					end else if (tick) begin
						ramp_r <= ramp_r + 12'h001;
					end
				end
				BCSC_ST_ON: begin
					dly_cnt_r <= 16'h0000;
					if (!en_now) begin
						state_r <= BCSC_ST_OFF_DLY;
					end else if (tick && ramp_r < vout_eff) begin
						ramp_r <= ramp_r + 12'h001;
					end else if (tick && ramp_r > vout_eff) begin
						ramp_r <= ramp_r - 12'h001;
					end
				end
				BCSC_ST_OFF_DLY: begin
					if (en_now) begin
						state_r <= BCSC_ST_ON;
					end else if (dly_cnt_r >= cfg_r[`BCSC_IDX_TOFF_DLY]) begin
						ramp_r     <= out_lvl;
						step_cnt_r <= 16'h0000;
						state_r    <= BCSC_ST_FALL;
					end else begin
						dly_cnt_r <= dly_cnt_r + 16'h0001;
					end
				end
				BCSC_ST_FALL: begin
					dly_cnt_r <= 16'h0000;
					if (en_now) begin
						state_r <= BCSC_ST_ON_DLY;
					end else if (ramp_r <= floor_lvl) begin
						state_r <= BCSC_ST_OFF;
					end else if (tick) begin
						ramp_r <= ramp_r - 12'h001;
					end
				end
				default: begin
					state_r <= BCSC_ST_OFF;
				end
			endcase
		end
	end

	// Driver outputs; the driver tristates whenever the sequencer is parked.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vout_target    <= 12'h000;
			driver_en      <= 1'b0;
			power_good_out <= 1'b0;
		end else begin
			vout_target    <= out_lvl;
			driver_en      <= state_r == BCSC_ST_RISE || state_r == BCSC_ST_ON ||
			                  state_r == BCSC_ST_OFF_DLY || state_r == BCSC_ST_FALL;
			power_good_out <= state_r == BCSC_ST_ON;
		end
	end

	// Lock window opens at each enable from the off state and on the relock command, then counts down.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_cnt_r <= '0;
			sync_d_r   <= 1'b0;
			sync_locked <= 1'b0;
		end else begin
			sync_d_r <= sync_s;
			if ((state_r == BCSC_ST_OFF && en_now) || (cmd_wr && w_data_r[`BCSC_CMD_RELOCK])) begin
				lock_cnt_r <= LW'(LOCK_WINDOW_CYC);
			end else if (lock_cnt_r != '0) begin
				lock_cnt_r <= lock_cnt_r - LW'(1);
			end
			if (sync_mode != BCSC_SYNC_IN) begin
				sync_locked <= 1'b0;
			end else if (lock_cnt_r != '0 && sync_s && !sync_d_r) begin
				sync_locked <= 1'b1;
			end
		end
	end

	// Switching clock; in input mode its phase follows external edges inside the window only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_cnt_r   <= '0;
			sw_phase_r <= 1'b0;
			sync_out   <= 1'b0;
			sync_oe    <= 1'b0;
		end else begin
			if (sync_mode == BCSC_SYNC_IN && lock_cnt_r != '0 && sync_s && !sync_d_r) begin
				sw_cnt_r   <= '0;
				sw_phase_r <= 1'b1;
			end else if (sw_cnt_r >= SWW'(SW_HALF_CYC - 1)) begin
				sw_cnt_r   <= '0;
				sw_phase_r <= ~sw_phase_r;
			end else begin
				sw_cnt_r <= sw_cnt_r + SWW'(1);
			end
			sync_oe  <= sync_mode == BCSC_SYNC_OUT;
			sync_out <= (sync_mode == BCSC_SYNC_OUT) & sw_phase_r;
		end
	end

	// Current telemetry filters; the trip path deliberately skips the average for speed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_r   <= '0;
			warn_r  <= 1'b0;
			oc_trip <= 1'b0;
			temp_r  <= 10'h000;
		end else begin
			acc_r   <= acc_r - (acc_r >> AVG_SHIFT) + ACW'(iout_sample);
			warn_r  <= acc_r[ACW-1:AVG_SHIFT] >= cfg_r[`BCSC_IDX_WARN_LIM][11:0];
			oc_trip <= iout_sample > cfg_r[`BCSC_IDX_OC_LIM][11:0];
			if ($signed(temp_raw) < $signed(`BCSC_TEMP_MIN)) begin
				temp_r <= `BCSC_TEMP_MIN;
			end else if ($signed(temp_raw) > $signed(`BCSC_TEMP_MAX)) begin
				temp_r <= `BCSC_TEMP_MAX;
			end else begin
				temp_r <= temp_raw;
			end
		end
	end

endmodule

// ===== rtl/bcsc_defines.svh
// Offsets, field positions, reset values and timing figures of the converter control block.
// Operation
// - Runtime configuration changes stay volatile and vanish at reset unless stored.
// - A stored configuration is loaded at every later power-up instead of defaults.
// - Strap-selected output voltage and compensation settings cannot be reprogrammed.
// - Storage holds three full stores, cost per changed parameter, space left readable.
// - Output voltage comes from the strap unless pin setup disables it; the code uses a strap-disable bit in the bus-written control word.
// - Power good stays high while the output voltage is changed dynamically.
// - Enable source is bus on command, control pin, or both combined.
// - Programmable turn-on and turn-off delays and rise and fall ramps sequence output.
// - Start into pre-charged output never pulls it down and keeps the rise time.
// - Disable ramps down to the off level, then tristates the output driver.
// - Tracking is off after reset, enabled only through the feature enable command.
// - With tracking the target is the lower of setting and tracking input.
// - Tracking enabled with a low or floating tracking input never starts the output.
// - Active tracking overrides a non-zero off level during shutdown.
// - Synchronization pin is off, clock input or clock output; off after reset.
// - Clock input locks only within 1ms of enable, relock on toggle or command.
// - In clock output mode the device drives its own switching clock on the pin.
// - Temperature report spans minus 40 to plus 150 degrees.
// - Output current is filtered and averaged for telemetry and warnings.
// - Overcurrent compares unfiltered samples against the threshold.
// - Soft-off ramps down at the fall time slew rate ending at the off level.
`ifndef BCSC_DEFINES_SVH
`define BCSC_DEFINES_SVH

`define BCSC_ADDR_W          8
`define BCSC_DATA_W          32
`define BCSC_CFG_W           16
`define BCSC_VOLT_W          12
`define BCSC_NCFG            9
`define BCSC_RESP_OKAY       2'h0
`define BCSC_RESP_SLVERR     2'h2

`define BCSC_IDX_CTRL        4'h0
`define BCSC_IDX_VOUT        4'h1
`define BCSC_IDX_VOFF        4'h2
`define BCSC_IDX_TON_DLY     4'h3
`define BCSC_IDX_TOFF_DLY    4'h4
`define BCSC_IDX_TON_RISE    4'h5
`define BCSC_IDX_TOFF_FALL   4'h6
`define BCSC_IDX_OC_LIM      4'h7
`define BCSC_IDX_WARN_LIM    4'h8

`define BCSC_OFF_CFG_LAST    8'h20
`define BCSC_OFF_CMD         8'h24
`define BCSC_OFF_STATUS      8'h28
`define BCSC_OFF_TARGET      8'h2C
`define BCSC_OFF_IOUT        8'h30
`define BCSC_OFF_TEMP        8'h34
`define BCSC_OFF_NVM_LEFT    8'h38
`define BCSC_OFF_STRAP       8'h3C

`define BCSC_CTRL_OPON       0
`define BCSC_CTRL_SRC_HI     2
`define BCSC_CTRL_SRC_LO     1
`define BCSC_CTRL_STRAP_DIS  3
`define BCSC_CTRL_SYNC_HI    5
`define BCSC_CTRL_SYNC_LO    4
`define BCSC_CTRL_TRACK_EN   6

`define BCSC_CMD_STORE_ALL   0
`define BCSC_CMD_STORE_CODE  1
`define BCSC_CMD_RELOCK      2

`define BCSC_DEF_CTRL        16'h0002
`define BCSC_DEF_VOUT        16'h0000
`define BCSC_DEF_VOFF        16'h0000
`define BCSC_DEF_DLY         16'h0010
`define BCSC_DEF_RAMP        16'h0002
`define BCSC_DEF_OC_LIM      16'h0FFF
`define BCSC_DEF_WARN_LIM    16'h0E00

`define BCSC_LOCK_WINDOW_US  1000
`define BCSC_CLK_MHZ         20
`define BCSC_TEMP_MIN        10'h3D8
`define BCSC_TEMP_MAX        10'h096

`endif

// ===== rtl/bcsc_pin_sync.sv
// Three-flop input synchronizer with agreement filter for pins from outside the clock domain.
`timescale 1ns/100ps
module bcsc_pin_sync (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin_in,
	output logic      level_out
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	// The first stage feeds only the second; the level moves once stages two and three agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r      <= 1'b0;
			s2_r      <= 1'b0;
			s3_r      <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_out <= s3_r;
			end
		end
	end

endmodule

// ===== rtl/bcsc_pkg.sv
// Types shared by the converter control block.
package bcsc_pkg;

	typedef enum logic [2:0] {
		BCSC_ST_OFF      = 3'h0,
		BCSC_ST_ON_DLY   = 3'h1,
		BCSC_ST_RISE     = 3'h2,
		BCSC_ST_ON       = 3'h3,
		BCSC_ST_OFF_DLY  = 3'h4,
		BCSC_ST_FALL     = 3'h5
	} bcsc_state_type;

	typedef enum logic [1:0] {
		BCSC_SRC_BUS  = 2'h0,
		BCSC_SRC_PIN  = 2'h1,
		BCSC_SRC_BOTH = 2'h2
	} bcsc_src_type;

	typedef enum logic [1:0] {
		BCSC_SYNC_OFF = 2'h0,
		BCSC_SYNC_IN  = 2'h1,
		BCSC_SYNC_OUT = 2'h2
	} bcsc_sync_type;

endpackage

// ===== tb/bcsc_ctrl_properties.sv
// Port checker of the converter control block.
`timescale 1ns/100ps
module bcsc_ctrl_check (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        sync_out,
	input wire logic        sync_oe,
	input wire logic        sync_locked,
	input wire logic        driver_en,
	input wire logic        power_good_out,
	input wire logic [11:0] vout_target
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sync_idle_a:
		assert property (!sync_oe |-> !sync_out) else $error("sync pin active while released");
	sync_drive_a:
		assert property (sync_oe |-> ##[1:17] ($changed(sync_out) || !sync_oe))
		else $error("own sync clock stalled");
	lock_mode_a:
		assert property (sync_locked |-> !sync_oe) else $error("locked while driving sync");
	pg_driver_a:
		assert property (power_good_out |-> driver_en) else $error("power good with driver off");
	start_ramp_a:
		assert property ($rose(driver_en) |-> !power_good_out) else $error("start without ramp");
	pg_slew_a:
		assert property ($past(power_good_out) && $changed(vout_target) |-> power_good_out)
		else $error("power good dropped during slew");
	bresp_hold_a:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	rdata_hold_a:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
endmodule
bind bcsc_ctrl bcsc_ctrl_check bcsc_ctrl_check_inst (.*);

// ===== tb/bcsc_sync_src.sv
// Far-side source of the external synchronization clock.
`timescale 1ns/100ps
module bcsc_sync_src (
	input  wire logic run,
	output logic      clk_out
);
	// The clock stands still low outside a run, so no stray edge reaches the pin.
	initial begin
		clk_out = 1'b0;
		forever begin
			#200 clk_out = run ? ~clk_out : 1'b0;
		end
	end
endmodule

// ===== tb/buck_config_sequencing_ctrl_test.sv
// Register-level bench of the converter control block.
`timescale 1ns/100ps
module buck_config_sequencing_ctrl_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ctrl_pin, sync_in, sync_out, sync_oe, nvm_valid_in, nvm_wr;
	logic driver_en, power_good_out, sync_locked, oc_trip, run;
	logic [7:0] s_axi_awaddr, s_axi_araddr, nvm_space_in;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [11:0] vout_strap_resistor, comp_strap_resistor, tracking_input, vout_sense_in;
	logic [11:0] iout_sample, vout_target;
	logic [9:0] temp_raw;
	logic [143:0] nvm_image_in, nvm_image_out, img;
	int errors, checks_done, n, stores;
	wire [3:0] flags = {sync_oe, sync_locked, power_good_out, driver_en};
	bcsc_ctrl #(.LOCK_WINDOW_CYC(200)) bcsc_ctrl_inst (.*);
	bcsc_sync_src bcsc_sync_src_inst (.run(run), .clk_out(sync_in));
	// Clock generator.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Store pulses are counted here since they last a single cycle.
	always @(posedge aclk) begin
		if (nvm_wr === 1'b1) begin
			stores++;
			img <= nvm_image_out;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Waits under a bound for one status output to reach a level.
	task wt(input int sel, input logic v);
		n = 0;
		while (flags[sel] !== v && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(flags[sel]), 32'(v));
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// The watchdog allows several times the expected run length.
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		results;
	end
	// The external clock runs from the start, ahead of any enable.
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, ctrl_pin, nvm_valid_in, vout_sense_in, nvm_image_in} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		run = 1'b1;
		vout_strap_resistor = 12'h0A5;
		comp_strap_resistor = 12'h05A;
		tracking_input = 12'hFFF;
		iout_sample = 12'h123;
		temp_raw = 10'h380;
		nvm_space_in = 8'h08;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(8'h00); chk(d, 32'h2);
		rd(8'h3C); chk(d, 32'h005A00A5);
		wr(8'h04, 32'h80); chk(r, 2'h2);
		rd(8'h40); chk(r, 2'h2);
		rd(8'h34); chk(d[9:0], 10'h3D8);
		// The default source is the control pin, and the strap code sets the level.
		ctrl_pin <= 1'b1;
		wt(1, 1'b1);
		rd(8'h2C);
		chk(d, 32'hA5);
		ctrl_pin <= 1'b0;
		wt(0, 1'b0);
		$display("test reset done");
		wr(8'h00, 32'h18);
		wr(8'h04, 32'h80); chk(r, 2'h0);
		wr(8'h00, 32'h19); wt(1, 1'b1);
		rd(8'h2C); chk(d, 32'h80);
		wt(2, 1'b1);
		wr(8'h04, 32'h60);
		wr(8'h24, 32'h1);
		rd(8'h38); chk(d, 32'h6);
		chk(stores, 1);
		// Later writes are not stored, so the power cycle below still sees the old image.
		chk(32'(oc_trip), 32'h0);
		wr(8'h1C, 32'h100);
		rd(8'h30);
		chk(d, 32'h123);
		chk(32'(oc_trip), 32'h1);
		wr(8'h08, 32'h20);
		$display("test enable done");
		wr(8'h00, 32'h18); wt(0, 1'b0);
		rd(8'h2C); chk(d, 32'h20);
		wr(8'h00, 32'h28); wt(3, 1'b1);
		$display("test disable done");
		// A low tracking input parks the start; a higher one caps the target.
		tracking_input <= 12'h008;
		wr(8'h00, 32'h59);
		repeat (40) @(posedge aclk);
		rd(8'h28);
		chk(d[4:0], 5'h01);
		tracking_input <= 12'h040;
		wt(1, 1'b1);
		rd(8'h2C);
		chk(d, 32'h40);
		wr(8'h00, 32'h58);
		wt(0, 1'b0);
		rd(8'h2C);
		chk(d, 32'h0);
		$display("test tracking done");
		aresetn <= 1'b0;
		nvm_valid_in <= 1'b1;
		nvm_image_in <= img;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(8'h00); chk(d, 32'h19);
		rd(8'h04); chk(d, 32'h60);
		$display("test power cycle done");
		results;
	end
endmodule
